// file: led_polarity_defines.svh
// Function
// - eleven polarity bits, two registers, reset zero
// - polarity write copies into duty reference bit
// - linked touch acts like request bit set
// - inverted polarity drives active pin low
// - non-inverted: high, or released when open-drain
// - inverted duty sets pin low fraction
// - inverted idle channel runs at minimum duty
// - inverted breathe ramps minimum up to maximum
// - non-inverted duty sets pin high fraction
// - non-inverted idle runs full minus minimum
// - non-inverted breathe ramps full-min to full-max
// - reference bit never flips pin drive sense
// - non-inverted brightness follows full minus setting
// - nine transition bits, two registers, reset zero
// - transition bits combine with inverted-link select
// - clear transition bit: linking untouched LED changes
// - reference bit: duty relative full or zero
`ifndef LED_POLARITY_DEFINES_SVH
`define LED_POLARITY_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_POL_LOW   8'h75
`define ADDR_POL_HIGH  8'h76
`define ADDR_TRAN_LOW  8'h77
`define ADDR_TRAN_HIGH 8'h78
`define ADDR_REF_LOW   8'h79
`define ADDR_REF_HIGH  8'h7A

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define RST_REG8       8'h00
`define CHANNELS       11
`define POL_HIGH_BITS  3
`define TRAN_LOW_BITS  7
`define TRAN_HIGH_BITS 2

// ----------------------------------------------------------------
// duty timing: one period is DUTY_FULL ticks of mclk
// ----------------------------------------------------------------
`define DUTY_FULL      5'h10
`endif

// file: led_polarity_pkg.sv
package led_polarity_pkg;
  typedef logic [10:0] chan_vec_t;
  typedef logic [3:0]  duty_t;
  typedef logic [4:0]  level_t;
  typedef logic [7:0]  reg8_t;
endpackage

// file: led_polarity_link_transition.sv
`include "led_polarity_defines.svh"

module led_polarity_link_transition
  import led_polarity_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire logic      clkEn,
  input  wire reg8_t     regAddr,
  input  wire reg8_t     regWrData,
  input  wire logic      regWe,
  input  wire logic      regRe,
  input  wire chan_vec_t channelOutputRequestBit,
  input  wire chan_vec_t channelDriveTypeBit,
  input  wire chan_vec_t sensorLink,
  input  wire chan_vec_t touchDetect,
  input  wire chan_vec_t breatheEnable,
  input  wire logic      blockPolarityToReferenceCoupling,
  input  wire logic      invertedLinkTransitionSelect,
  input  wire duty_t     minDuty,
  input  wire duty_t     maxDuty,
  output reg8_t          regRdData,
  output chan_vec_t      channelDutyReferenceBit,
  output chan_vec_t      pinOut,
  output chan_vec_t      pinOe
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  chan_vec_t channelPolarityBit;
  logic [8:0] channelLinkTransitionBit; // [6:0] ch1-7, [8:7] ch9-10
  chan_vec_t transMap;
  logic [3:0] periodCnt;
  chan_vec_t actuated;
  chan_vec_t holdOn;
  chan_vec_t onPhase;
  chan_vec_t next_pinOut;
  chan_vec_t next_pinOe;
  level_t    level [`CHANNELS];
  level_t    ramp [`CHANNELS];
  logic      wrPolLow;
  logic      wrPolHigh;

  assign wrPolLow  = clkEn && regWe && regAddr == `ADDR_POL_LOW;
  assign wrPolHigh = clkEn && regWe && regAddr == `ADDR_POL_HIGH;

  // spread transition bits onto channel positions; ch8 and ch11 have none
  assign transMap = {1'b0, channelLinkTransitionBit[8:7], 1'b0,
                     channelLinkTransitionBit[6:0]};

  // polarity registers, upper bits of the high one not stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channelPolarityBit <= '0;
    end else begin
      if (wrPolLow) begin
        channelPolarityBit[7:0] <= regWrData;
      end
      if (wrPolHigh) begin
        channelPolarityBit[10:8] <= regWrData[`POL_HIGH_BITS-1:0];
      end
    end
  end

  // transition registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channelLinkTransitionBit <= '0;
    end else if (clkEn && regWe) begin
      if (regAddr == `ADDR_TRAN_LOW) begin
        channelLinkTransitionBit[6:0] <= regWrData[`TRAN_LOW_BITS-1:0];
      end
      if (regAddr == `ADDR_TRAN_HIGH) begin
        channelLinkTransitionBit[8:7] <= regWrData[`TRAN_HIGH_BITS-1:0];
      end
    end
  end

  // duty reference bits, also follow polarity writes unless blocked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channelDutyReferenceBit <= '0;
    end else if (clkEn && regWe) begin
      if (regAddr == `ADDR_REF_LOW) begin
        channelDutyReferenceBit[7:0] <= regWrData;
      end
      if (regAddr == `ADDR_REF_HIGH) begin
        channelDutyReferenceBit[10:8] <= regWrData[2:0];
      end
      if (wrPolLow && !blockPolarityToReferenceCoupling) begin
        channelDutyReferenceBit[7:0] <= regWrData;
      end
      if (wrPolHigh && !blockPolarityToReferenceCoupling) begin
        channelDutyReferenceBit[10:8] <= regWrData[2:0];
      end
    end
  end

  // register read port, unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= `RST_REG8;
    end else if (clkEn && regRe) begin
      case (regAddr)
        `ADDR_POL_LOW:   regRdData <= channelPolarityBit[7:0];
        `ADDR_POL_HIGH:  regRdData <= {5'h0, channelPolarityBit[10:8]};
        `ADDR_TRAN_LOW:  regRdData <= {1'b0, channelLinkTransitionBit[6:0]};
        `ADDR_TRAN_HIGH: regRdData <= {6'h0, channelLinkTransitionBit[8:7]};
        `ADDR_REF_LOW:   regRdData <= channelDutyReferenceBit[7:0];
        `ADDR_REF_HIGH:  regRdData <= {5'h0, channelDutyReferenceBit[10:8]};
        default:         regRdData <= `RST_REG8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pwm period counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periodCnt <= 4'h0;
    end else if (clkEn) begin
      periodCnt <= periodCnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel actuation, duty level and pin drive
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch++) begin : g_chan
      level_t sel;
      logic   linkedAct;

      // held-on flag: linking while requested and transition bit set
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          holdOn[ch] <= 1'b0;
        end else if (clkEn) begin
          if (!sensorLink[ch] || !channelOutputRequestBit[ch]) begin
            holdOn[ch] <= 1'b0;
          end else if (!holdOn[ch] && transMap[ch] && !touchDetect[ch]) begin
            holdOn[ch] <= 1'b1;
          end
        end
      end

      // linked channel: plain touch, or held state per inverted select
      always_comb begin
        if (holdOn[ch]) begin
          linkedAct = invertedLinkTransitionSelect ? !touchDetect[ch] : 1'b1;
        end else begin
          linkedAct = touchDetect[ch];
        end
        actuated[ch] = sensorLink[ch] ? linkedAct : channelOutputRequestBit[ch];
      end

      // breathe ramp climbs one step per period from min toward max
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ramp[ch] <= 5'h00;
        end else if (clkEn) begin
          if (!(actuated[ch] && breatheEnable[ch])) begin
            ramp[ch] <= {1'b0, minDuty};
          end else if (periodCnt == 4'hF && ramp[ch] < {1'b0, maxDuty}) begin
            ramp[ch] <= ramp[ch] + 5'h01;
          end
        end
      end

      // pick setting, then reference it to full or zero
      always_comb begin
        if (!actuated[ch]) begin
          sel = {1'b0, minDuty};
        end else if (breatheEnable[ch]) begin
          sel = ramp[ch];
        end else begin
          sel = {1'b0, maxDuty};
        end
        if (channelDutyReferenceBit[ch]) begin
          level[ch] = `DUTY_FULL - sel;
        end else begin
          level[ch] = sel;
        end
        onPhase[ch] = {1'b0, periodCnt} < level[ch];
      end

      // polarity alone sets drive sense; reference bit only moves level
      always_comb begin
        logic lvl;
        lvl = channelPolarityBit[ch] ? onPhase[ch] : !onPhase[ch];
        if (channelDriveTypeBit[ch]) begin
          next_pinOut[ch] = lvl;
          next_pinOe[ch]  = 1'b1;
        end else begin
          next_pinOut[ch] = 1'b0;
          next_pinOe[ch]  = !lvl;
        end
      end

      // push-pull pin lands one cycle after its sense is picked
      a_pp_sense: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && channelDriveTypeBit[ch]
          |=> pinOe[ch] && pinOut[ch] == ($past(channelPolarityBit[ch]) == $past(onPhase[ch])))
        else $error("push-pull pin sense wrong");

      // open-drain pin never drives high
      a_od_never_high: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && !channelDriveTypeBit[ch] |=> !pinOut[ch])
        else $error("open-drain pin driven high");

      // breathe ramp climbs one step per period while below maximum
      a_ramp_step: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && actuated[ch] && breatheEnable[ch] && periodCnt == 4'hF
          && ramp[ch] < {1'b0, maxDuty} |=> ramp[ch] == $past(ramp[ch]) + 5'h01)
        else $error("breathe ramp step wrong");

      a_ramp_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && !(actuated[ch] && breatheEnable[ch])
          |=> ramp[ch] == {1'b0, $past(minDuty)})
        else $error("breathe ramp did not restart at minimum");
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else if (clkEn) begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

  // ----------------------------------------------------------------
  // checks on register writes and reads, and on channel 0
  // ----------------------------------------------------------------
  sequence s_linkRise;
    !sensorLink[0] ##1 (clkEn && sensorLink[0] && channelOutputRequestBit[0]
                        && !touchDetect[0] && transMap[0] && !holdOn[0]);
  endsequence

  a_pol_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wrPolLow |=> channelPolarityBit[7:0] == $past(regWrData))
    else $error("polarity write lost");

  a_ref_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    wrPolLow && !blockPolarityToReferenceCoupling
      |=> channelDutyReferenceBit[7:0] == $past(regWrData))
    else $error("reference bit did not follow polarity");

  a_ref_blocked: assert property (@(posedge mclk) disable iff (!rst_n)
    wrPolLow && blockPolarityToReferenceCoupling |=> $stable(channelDutyReferenceBit))
    else $error("reference bit changed while blocked");

  a_high_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && regRe && regAddr == `ADDR_TRAN_HIGH |=> regRdData[7:2] == 6'h00)
    else $error("unused transition bits not zero");

  a_touch_acts: assert property (@(posedge mclk) disable iff (!rst_n)
    sensorLink[0] && touchDetect[0] && !holdOn[0] |-> actuated[0])
    else $error("linked touch did not actuate");

  a_inv_low: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && !channelPolarityBit[0] && onPhase[0] |=> pinOe[0] && !pinOut[0])
    else $error("inverted on phase not low");

  a_od_release: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && channelPolarityBit[0] && onPhase[0] && !channelDriveTypeBit[0]
      |=> !pinOe[0])
    else $error("open-drain high not released");

  a_idle_min: assert property (@(posedge mclk) disable iff (!rst_n)
    !actuated[0] && !channelDutyReferenceBit[0] |-> level[0] == {1'b0, minDuty})
    else $error("idle level not minimum");

  a_idle_full: assert property (@(posedge mclk) disable iff (!rst_n)
    !actuated[0] && channelDutyReferenceBit[0]
      |-> level[0] == `DUTY_FULL - {1'b0, minDuty})
    else $error("idle level not full minus minimum");

  a_link_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    s_linkRise |=> holdOn[0])
    else $error("transition hold not taken");

  // ----------------------------------------------------------------
  // checks on the register port
  // ----------------------------------------------------------------
  // high polarity write keeps its three bits
  a_pol_high_write: assert property (@(posedge mclk) disable iff (!rst_n)
    wrPolHigh |=> channelPolarityBit[10:8] == $past(regWrData[2:0]))
    else $error("high polarity write lost");

  // low transition write keeps its seven bits
  a_tran_write: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && regWe && regAddr == `ADDR_TRAN_LOW
      |=> channelLinkTransitionBit[6:0] == $past(regWrData[6:0]))
    else $error("transition write lost");

  // unused polarity bits read zero
  a_pol_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    clkEn && regRe && regAddr == `ADDR_POL_HIGH |=> regRdData[7:3] == 5'h00)
    else $error("unused polarity bits not zero");

  // read data stands until the next read
  a_rd_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !(clkEn && regRe) |=> $stable(regRdData))
    else $error("read data moved without a read");

  // low clock enable freezes registers and pins
  a_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    !clkEn |=> $stable(channelPolarityBit) && $stable(pinOut) && $stable(pinOe))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------
  // checks on the held transition of channel 0
  // ----------------------------------------------------------------
  // channel held on while linked and requested
  sequence s_heldLinked;
    holdOn[0] && sensorLink[0] && channelOutputRequestBit[0];
  endsequence

  // link taken away on an enabled edge
  sequence s_unlink;
    clkEn && !sensorLink[0];
  endsequence

  // held channel stays on without inverted select
  a_hold_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    s_heldLinked ##0 !invertedLinkTransitionSelect |-> actuated[0])
    else $error("held channel dropped without inverted select");

  // held channel answers touch under inverted select
  a_hold_touch: assert property (@(posedge mclk) disable iff (!rst_n)
    s_heldLinked ##0 (invertedLinkTransitionSelect && touchDetect[0]) |-> !actuated[0])
    else $error("held channel ignored touch under inverted select");

  // linked channel without hold follows touch
  a_plain_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    sensorLink[0] && !holdOn[0] |-> actuated[0] == touchDetect[0])
    else $error("linked channel not following touch");

  // hold ends once the link goes away
  a_hold_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    s_unlink |=> !holdOn[0])
    else $error("hold kept after unlinking");

endmodule // led_polarity_link_transition

// file: led_load_model.sv
module led_load_model
  import led_polarity_pkg::*;
(
  input  wire chan_vec_t pinOut,
  input  wire chan_vec_t pinOe,
  output chan_vec_t      pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // pin level seen by the leds
  // ----------------------------------------
  // a released pin is pulled high, so the led sinks no current
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
    end
  end
endmodule // led_load_model

// file: tb_top.sv
module tb_top
  import led_polarity_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // stimulus, outputs and bookkeeping
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        regWe = 1'b0;
  logic        regRe = 1'b0;
  logic        blk = 1'b0;
  logic        inv = 1'b0;
  reg8_t       regAddr = 8'h00;
  reg8_t       regWrData = 8'h00;
  reg8_t       regRdData;
  reg8_t       rd;
  chan_vec_t   req = '0, dtype = '0, link = '0, touch = '0, breathe = '0;
  chan_vec_t   pol = '0, refBits = '0, refOut, pinOut, pinOe, pinLevel;
  duty_t       minDuty = 4'h0, maxDuty = 4'h0;
  logic [31:0] seed = 32'd56271;
  logic [31:0] d;
  int          n_fail = 0;
  int          compares = 0;

  always #4 mclk = ~mclk;

  led_polarity_link_transition dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWe(regWe), .regRe(regRe),
    .channelOutputRequestBit(req), .channelDriveTypeBit(dtype), .sensorLink(link),
    .touchDetect(touch), .breatheEnable(breathe), .blockPolarityToReferenceCoupling(blk),
    .invertedLinkTransitionSelect(inv), .minDuty(minDuty), .maxDuty(maxDuty),
    .regRdData(regRdData), .channelDutyReferenceBit(refOut), .pinOut(pinOut), .pinOe(pinOe));

  led_load_model leds (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input reg8_t a, input reg8_t v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWe <= 1'b1;
    @(posedge mclk);
    regWe <= 1'b0;
  endtask

  task automatic rdReg(input reg8_t a, output reg8_t v);
    @(posedge mclk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge mclk);
    regRe <= 1'b0;
    #1;
    v = regRdData;
  endtask

  // expected low ticks per 16-tick period
  function automatic logic [4:0] expLow(input logic p, input logic r, input logic a);
    logic [4:0] l;
    l = a ? {1'b0, maxDuty} : {1'b0, minDuty};
    if (r) l = 5'h10 - l;
    return p ? 5'h10 - l : l;
  endfunction

  // count low ticks of every pin over one period; heldMask channels expect heldAct
  task automatic checkPins(input chan_vec_t heldMask, input chan_vec_t heldAct);
    logic [4:0] cnt [11];
    logic       act;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 11; i++) cnt[i] = 5'h00;
    repeat (16) begin
      @(posedge mclk);
      #1;
      for (int i = 0; i < 11; i++) cnt[i] += {4'h0, ~pinLevel[i]};
      chk(16'((pinOut & ~dtype) | (~pinOe & dtype)), 16'h0000);
    end
    for (int i = 0; i < 11; i++) begin
      act = heldMask[i] ? heldAct[i] : (link[i] ? touch[i] : req[i]);
      chk(16'(cnt[i]), 16'(expLow(pol[i], refBits[i], act)));
    end
  endtask

  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 8'h75; a <= 8'h78; a++) begin
      rdReg(8'(a), rd);
      chk(16'(rd), 16'h0000);
    end
    rdReg(8'h90, rd);
    chk(16'(rd), 16'h0000);
    repeat (4) begin
      d = xs();
      wr(8'h75, d[7:0]);
      wr(8'h76, d[15:8]);
      wr(8'h77, d[23:16]);
      wr(8'h78, d[31:24]);
      pol = {d[10:8], d[7:0]};
      refBits = pol;
      rdReg(8'h75, rd);
      chk(16'(rd), 16'(d[7:0]));
      rdReg(8'h76, rd);
      chk(16'(rd), 16'({5'h00, d[10:8]}));
      rdReg(8'h77, rd);
      chk(16'(rd), 16'({1'b0, d[22:16]}));
      rdReg(8'h78, rd);
      chk(16'(rd), 16'({6'h00, d[25:24]}));
      chk(16'(refOut), 16'(refBits));
    end
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(8'h75, ~pol[7:0]);
    clkEn <= 1'b1;
    rdReg(8'h75, rd);
    chk(16'(rd), 16'(pol[7:0]));
    wr(8'h77, 8'h00);
    wr(8'h78, 8'h00);
    $display("test registers done");
    repeat (8) begin
      d = xs();
      @(posedge mclk);
      blk <= d[31];
      inv <= d[30];
      wr(8'h75, d[7:0]);
      pol[7:0] = d[7:0];
      if (!d[31]) refBits[7:0] = d[7:0];
      @(negedge mclk);
      chk(16'(refOut), 16'(refBits));
      d = xs();
      @(posedge mclk);
      req <= d[10:0];
      link <= d[21:11] & 11'h37F;
      touch <= {d[31:22], d[0]};
      minDuty <= d[25:22];
      maxDuty <= d[29:26];
      d = xs();
      dtype <= d[10:0];
      checkPins('0, '0);
    end
    $display("test pins done");
    // corner: link requested, untouched channel 1 with its transition bit set
    wr(8'h77, 8'h01);
    req <= 11'h001;
    link <= '0;
    touch <= '0;
    inv <= 1'b0;
    @(posedge mclk);
    link <= 11'h001;
    checkPins(11'h001, 11'h001);
    @(posedge mclk);
    inv <= 1'b1;
    touch <= 11'h001;
    checkPins(11'h001, 11'h000);
    @(posedge mclk);
    link <= '0;
    touch <= '0;
    wr(8'h77, 8'h00);
    link <= 11'h001;
    checkPins('0, '0);
    $display("test transition done");
    // corner: every channel breathing from 2 up to 9
    @(posedge mclk);
    link <= '0;
    req <= '1;
    minDuty <= 4'h2;
    maxDuty <= 4'h9;
    @(posedge mclk);
    breathe <= '1;
    repeat (160) @(posedge mclk);
    checkPins('0, '0);
    $display("test breathe done");
    wrap_up();
  end
endmodule // tb_top
